// ### core/cfc_pkg.sv
/*
  Shared constants, modes and carrier types for the per-channel flow
  control block. Assumes one 200 MHz clock and 8-bit channel characters.
*/
package cfc_pkg;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 5;
  localparam int PROMPT_INTERVAL_US = 1000;
  localparam int PROMPT_CYCLES      =
    (PROMPT_INTERVAL_US * 1000) / CLK_PERIOD_NS;

  // --------------------------------------------------------------------
  // Characters and buffer levels
  // --------------------------------------------------------------------
  localparam int       CHAR_W       = 8;
  localparam logic [7:0] RESUME_CHAR = 8'h11;
  localparam logic [7:0] STOP_CHAR   = 8'h13;
  localparam int       FIFO_DEPTH   = 16;
  localparam int       STOP_LEVEL   = 12;
  localparam int       RESUME_LEVEL = 4;

  // --------------------------------------------------------------------
  // Channel types and flow control modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CFC_CHAN_ASYNC,
    CFC_CHAN_SWITCHED,
    CFC_CHAN_SYNC
  } cfc_chan_e;

  typedef enum logic [3:0] {
    CFC_FLOW_NONE,
    CFC_FLOW_DSR_DTR,
    CFC_FLOW_CTS_RTS,
    CFC_GO_HIGH_PEER_HIGH_MODE,
    CFC_GO_HIGH_PEER_LOW_MODE,
    CFC_GO_LOW_PEER_HIGH_MODE,
    CFC_GO_LOW_PEER_LOW_MODE,
    CFC_INBAND_BIDIRECTIONAL_MODE,
    CFC_INBAND_COMPUTER_END_MODE,
    CFC_INBAND_TERMINAL_END_MODE,
    CFC_PROMPTING_BIDIRECTIONAL_MODE,
    CFC_PROMPTING_COMPUTER_END_MODE,
    CFC_PROMPTING_TERMINAL_END_MODE
  } cfc_flow_e;

  // Channel configuration carried as one bundle
  typedef struct packed {
    cfc_chan_e chan_type;
    cfc_flow_e local_mode;
    cfc_flow_e remote_mode;
  } cfc_cfg_s;

  // Channel status bundle
  typedef struct packed {
    logic stopping;
    logic peer_paused;
    logic half_duplex;
  } cfc_status_s;

endpackage

// ### core/cfc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a fill level.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cfc_fifo
  import cfc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       reset_i,
  // Fill side
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  // Drain side
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]      level_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("cfc_fifo: DEPTH must be at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // Handshakes come straight from the fill level
  assign in_ready_o  = (level_o != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_o = (level_o != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Pointers wrap at the depth
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // Fill level
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      level_o <= '0;
    else if (push && !pop)
      level_o <= level_o + 1'b1;
    else if (pop && !push)
      level_o <= level_o - 1'b1;
  end

endmodule
`default_nettype wire

// ### core/cfc_prompt_timer.sv
/*
  Periodic tick for the prompting flow modes. Gives a one-cycle pulse
  every INTERVAL cycles while enabled; restarts when disabled.
*/
`timescale 1ns/10ps
`default_nettype none
module cfc_prompt_timer
  import cfc_pkg::*;
#(
  parameter int INTERVAL = PROMPT_CYCLES
)
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Control and tick
  input  wire logic enable_i,
  output logic      tick_o
);

  localparam int CW = $clog2(INTERVAL + 1);

  initial
  begin
    if (INTERVAL < 2)
      $error("cfc_prompt_timer: INTERVAL must be at least 2");
  end

  logic [CW-1:0] count;

  // Count down and reload
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !enable_i)
    begin
      count  <= CW'(INTERVAL - 1);
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (count == '0);
      count  <= (count == '0) ? CW'(INTERVAL - 1) : count - 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### core/cfc_channel_flow_control.sv
/*
  Per-channel flow control: buffers characters from the attached device,
  tells it to stop and resume by modem lines or by in-band characters,
  and obeys its own stop/resume indications. Assumes a character UART on
  both sides on the same clock and modem-line pins from outside.
*/
`timescale 1ns/10ps
`default_nettype none
module cfc_channel_flow_control
  import cfc_pkg::*;
#(
  parameter int DEPTH           = FIFO_DEPTH,
  parameter int STOP_AT         = STOP_LEVEL,
  parameter int RESUME_AT       = RESUME_LEVEL,
  parameter int PROMPT_INTERVAL = PROMPT_CYCLES
)
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  // Configuration and status
  input  wire cfc_cfg_s          cfg_i,
  output cfc_flow_e              remote_mode_o,
  output cfc_status_s            status_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o,
  // Characters received from the attached device
  input  wire logic              rx_valid_i,
  output logic                   rx_ready_o,
  input  wire logic [7:0]        rx_data_i,
  // Buffered characters toward the link
  output logic                   link_valid_o,
  input  wire logic              link_ready_i,
  output logic [7:0]             link_data_o,
  // Characters from the link toward the device
  input  wire logic              txs_valid_i,
  output logic                   txs_ready_o,
  input  wire logic [7:0]        txs_data_i,
  // Characters to the device transmitter
  output logic                   dev_valid_o,
  input  wire logic              dev_ready_i,
  output logic [7:0]             dev_data_o,
  // Modem-control pins
  input  wire logic              dtr_i,
  input  wire logic              rts_i,
  input  wire logic              reverse_carrier_input_i,
  output logic                   dsr_o,
  output logic                   cts_o
);

  localparam int LW = $clog2(DEPTH + 1);

  initial
  begin
    if (!(RESUME_AT < STOP_AT && STOP_AT < DEPTH && RESUME_AT >= 0))
      $error("cfc: need RESUME_AT < STOP_AT < DEPTH");
  end

  // --------------------------------------------------------------------
  // Mode decoding
  // --------------------------------------------------------------------
  // Mode checked against channel type; unsupported mode acts as none
  function automatic cfc_flow_e eff_mode(cfc_chan_e t, cfc_flow_e m);
    eff_mode = m;
    if (t == CFC_CHAN_SYNC)
    begin
      if (m != CFC_FLOW_CTS_RTS)
        eff_mode = CFC_FLOW_NONE;
    end
    else if (m == CFC_FLOW_CTS_RTS)
      eff_mode = CFC_FLOW_NONE;
  endfunction

  function automatic logic is_polar(cfc_flow_e m);
    is_polar = (m >= CFC_GO_HIGH_PEER_HIGH_MODE) &&
               (m <= CFC_GO_LOW_PEER_LOW_MODE);
  endfunction

  function automatic logic is_prompt(cfc_flow_e m);
    is_prompt = (m >= CFC_PROMPTING_BIDIRECTIONAL_MODE);
  endfunction

  // Sends stop/resume characters of its own
  function automatic logic sends_chars(cfc_flow_e m);
    sends_chars = (m == CFC_INBAND_BIDIRECTIONAL_MODE) ||
                  (m == CFC_INBAND_COMPUTER_END_MODE) ||
                  (m == CFC_PROMPTING_BIDIRECTIONAL_MODE) ||
                  (m == CFC_PROMPTING_COMPUTER_END_MODE);
  endfunction

  // Obeys received stop/resume characters
  function automatic logic obeys_chars(cfc_flow_e m);
    obeys_chars = (m == CFC_INBAND_BIDIRECTIONAL_MODE) ||
                  (m == CFC_INBAND_TERMINAL_END_MODE) ||
                  (m == CFC_PROMPTING_BIDIRECTIONAL_MODE) ||
                  (m == CFC_PROMPTING_TERMINAL_END_MODE);
  endfunction

  cfc_chan_e chan;
  cfc_flow_e mode;
  logic      send_m;
  logic      obey_m;

  // Settings held in flops; local and remote kept apart
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      chan          <= CFC_CHAN_ASYNC;
      mode          <= CFC_FLOW_NONE;
      remote_mode_o <= CFC_FLOW_NONE;
    end
    else
    begin
      chan          <= cfg_i.chan_type;
      mode          <= eff_mode(cfg_i.chan_type, cfg_i.local_mode);
      remote_mode_o <= cfg_i.remote_mode;
    end
  end

  assign send_m = sends_chars(mode);
  assign obey_m = obeys_chars(mode);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {reverse_carrier_input_i, rts_i, dtr_i};
      pin_sync <= pin_meta;
    end
  end

  // --------------------------------------------------------------------
  // Receive path and buffer
  // --------------------------------------------------------------------
  logic rx_is_stop;
  logic rx_is_resume;
  logic rx_consume;
  logic fifo_in_valid;
  logic fifo_in_ready;

  // Flow characters are taken out of the stream only when obeyed
  assign rx_is_stop    = rx_valid_i && (rx_data_i == STOP_CHAR);
  assign rx_is_resume  = rx_valid_i && (rx_data_i == RESUME_CHAR);
  assign rx_consume    = obey_m && (rx_is_stop || rx_is_resume);
  assign fifo_in_valid = rx_valid_i && !rx_consume;
  assign rx_ready_o    = rx_consume || fifo_in_ready;

  cfc_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_data_i),
    .out_valid_o (link_valid_o),
    .out_ready_i (link_ready_i),
    .out_data_o  (link_data_o),
    .level_o     (level_o)
  );

  // --------------------------------------------------------------------
  // Stop state with hysteresis
  // --------------------------------------------------------------------
  logic stopping;
  logic stop_rise;
  logic stop_fall;
  logic next_stopping;

  always_comb
  begin
    next_stopping = stopping;
    if (level_o >= LW'(STOP_AT))
      next_stopping = 1'b1;
    else if (level_o <= LW'(RESUME_AT))
      next_stopping = 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      stopping <= 1'b0;
    else
      stopping <= next_stopping;
  end

  assign stop_rise = next_stopping && !stopping;
  assign stop_fall = !next_stopping && stopping;

  // --------------------------------------------------------------------
  // Peer pause from received characters
  // --------------------------------------------------------------------
  logic peer_paused;

  always_ff @(posedge clock_i)
  begin
    if (reset_i || !obey_m)
      peer_paused <= 1'b0;
    else if (rx_consume && rx_is_stop)
      peer_paused <= 1'b1;
    else if (rx_consume && rx_is_resume)
      peer_paused <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Modem-line outputs and duplex
  // --------------------------------------------------------------------
  logic go_high;
  logic peer_high;

  assign go_high   = (mode == CFC_GO_HIGH_PEER_HIGH_MODE) ||
                     (mode == CFC_GO_HIGH_PEER_LOW_MODE);
  assign peer_high = (mode == CFC_GO_HIGH_PEER_HIGH_MODE) ||
                     (mode == CFC_GO_LOW_PEER_HIGH_MODE);

  // Lines default asserted when not used for flow control
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      dsr_o    <= 1'b1;
      cts_o    <= 1'b1;
      status_o <= '0;
    end
    else
    begin
      dsr_o <= (mode == CFC_FLOW_DSR_DTR) ? !stopping : 1'b1;
      if (mode == CFC_FLOW_CTS_RTS)
        cts_o <= !stopping;
      else if (is_polar(mode))
        cts_o <= go_high ? !stopping : stopping;
      else
        cts_o <= 1'b1;
      status_o.stopping    <= stopping;
      status_o.peer_paused <= peer_paused;
      status_o.half_duplex <= (chan == CFC_CHAN_SYNC) &&
                              (mode == CFC_FLOW_CTS_RTS);
    end
  end

  // --------------------------------------------------------------------
  // Transmit permission
  // --------------------------------------------------------------------
  logic tx_allow;

  always_comb
  begin
    case (mode)
      CFC_FLOW_DSR_DTR:
        tx_allow = pin_sync[0];
      CFC_FLOW_CTS_RTS:
        tx_allow = pin_sync[1];
      CFC_GO_HIGH_PEER_HIGH_MODE, CFC_GO_HIGH_PEER_LOW_MODE,
      CFC_GO_LOW_PEER_HIGH_MODE, CFC_GO_LOW_PEER_LOW_MODE:
        tx_allow = (pin_sync[2] == peer_high);
      default:
        tx_allow = !peer_paused;
    endcase
  end

  // --------------------------------------------------------------------
  // Flow character requests
  // --------------------------------------------------------------------
  logic prompt_tick;
  logic pend_stop;
  logic pend_resume;
  logic tx_load;
  logic sent_stop;
  logic sent_resume;
  logic data_after_stop;

  cfc_prompt_timer #(
    .INTERVAL (PROMPT_INTERVAL)
  ) u_prompt (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .enable_i (is_prompt(mode) && send_m),
    .tick_o   (prompt_tick)
  );

  assign tx_load     = !dev_valid_o || dev_ready_i;
  assign sent_stop   = tx_load && pend_stop;
  assign sent_resume = tx_load && !pend_stop && pend_resume;
  assign data_after_stop = stopping && fifo_in_valid && fifo_in_ready;

  // New requests win over the send that would clear them
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !send_m)
    begin
      pend_stop   <= 1'b0;
      pend_resume <= 1'b0;
    end
    else
    begin
      if (stop_rise ||
          (is_prompt(mode) && data_after_stop))
        pend_stop <= 1'b1;
      else if (sent_stop || stop_fall)
        pend_stop <= 1'b0;
      if (stop_fall ||
          (is_prompt(mode) && prompt_tick && !stopping))
        pend_resume <= 1'b1;
      else if (sent_resume || stop_rise)
        pend_resume <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Transmit output stage
  // --------------------------------------------------------------------
  logic tx_is_flow;

  assign txs_ready_o = tx_load && !pend_stop && !pend_resume && tx_allow;

  // Flow characters go first and are not held by the peer's pause
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      dev_valid_o <= 1'b0;
      dev_data_o  <= 8'h00;
      tx_is_flow  <= 1'b0;
    end
    else if (tx_load)
    begin
      dev_valid_o <= pend_stop || pend_resume || (txs_valid_i && tx_allow);
      tx_is_flow  <= pend_stop || pend_resume;
      if (pend_stop)
        dev_data_o <= STOP_CHAR;
      else if (pend_resume)
        dev_data_o <= RESUME_CHAR;
      else
        dev_data_o <= txs_data_i;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_mode_held;
    $stable(mode) ##1 $stable(mode);
  endsequence

  sequence s_peer_stop;
    rx_consume && rx_is_stop;
  endsequence

  a_stop_on_level: assert property (
    level_o >= LW'(STOP_AT) |=> stopping)
    else $error("stop not raised at stop level");

  a_resume_on_level: assert property (
    stopping && level_o <= LW'(RESUME_AT) |=> !stopping)
    else $error("stop not dropped at resume level");

  a_dsr_follow: assert property (
    mode == CFC_FLOW_DSR_DTR ##1 s_mode_held |-> dsr_o == !$past(stopping))
    else $error("DSR does not follow buffer state");

  a_cts_polar: assert property (
    is_polar(mode) && $stable(mode) |=> cts_o == ($past(go_high) ^ $past(stopping)))
    else $error("CTS polarity wrong");

  a_peer_pause: assert property (
    s_peer_stop ##1 (obey_m && !(rx_consume && rx_is_resume)) |=> !txs_ready_o)
    else $error("send not paused after stop character");

  a_ignore_chars: assert property (
    mode == CFC_INBAND_COMPUTER_END_MODE && rx_is_stop |-> fifo_in_valid && !rx_consume)
    else $error("stop character not passed through");

  a_terminal_quiet: assert property (
    $past(mode) == CFC_INBAND_TERMINAL_END_MODE &&
    mode == CFC_INBAND_TERMINAL_END_MODE && tx_load |=> !tx_is_flow)
    else $error("flow character sent in terminal-end mode");

  a_stop_char_first: assert property (
    pend_stop && tx_load |=> dev_valid_o && dev_data_o == STOP_CHAR && tx_is_flow)
    else $error("stop character not sent");

  a_prompt_resume: assert property (
    send_m && is_prompt(mode) && prompt_tick && !stopping |=> pend_resume || $past(sent_resume) || !send_m)
    else $error("prompt resume not requested");

  a_half_duplex: assert property (
    chan == CFC_CHAN_SYNC && mode == CFC_FLOW_CTS_RTS |=> status_o.half_duplex)
    else $error("sync clear-to-send channel not half duplex");

endmodule
`default_nettype wire

// ### verif/cfc_peer_model.sv
/*
  Attached serial device: takes characters from the channel transmitter,
  promptly or with stalls, counts stop and resume characters and keeps the last data character.
  Assumes the block's clock and active-high synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cfc_peer_model
  import cfc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  // Channel transmitter side
  input  wire logic       dev_valid_i,
  input  wire logic [7:0] dev_data_i,
  output logic            dev_ready_o,
  // Pace and counts
  input  wire logic       slow_i,
  output logic [7:0]      stop_cnt_o,
  output logic [7:0]      resume_cnt_o,
  output logic [7:0]      last_data_o
);
  logic toggle;

  // Ready every cycle, or every other cycle when stalling
  always_ff @(posedge clock_i)
  begin
    toggle <= reset_i ? 1'b0 : !toggle;
  end
  assign dev_ready_o = !slow_i || toggle;

  // Same stop/resume coding as the channel, as the far end must use
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      stop_cnt_o   <= 8'h00;
      resume_cnt_o <= 8'h00;
      last_data_o  <= 8'h00;
    end
    else if (dev_valid_i && dev_ready_o)
    begin
      if (dev_data_i == STOP_CHAR)
        stop_cnt_o <= stop_cnt_o + 8'h01;
      else if (dev_data_i == RESUME_CHAR)
        resume_cnt_o <= resume_cnt_o + 8'h01;
      else
        last_data_o <= dev_data_i;
    end
  end
endmodule
`default_nettype wire

// ### verif/channel_flow_control_bench.sv
/*
  Self-checking bench of the channel flow control block with an attached
  device model. Assumes the block parameters of the package, except a prompt interval of 16 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module channel_flow_control_bench;
  import cfc_pkg::*;
  logic clock_i = 0, reset_i = 1, rxv = 0, lrdy = 0, txv = 0, slow = 0;
  logic dtr = 1, rts = 1, rc = 1, rx_ready, link_valid, txs_ready;
  logic dev_valid, dev_ready, dsr, cts, ok;
  logic [7:0] rxd = 0, txd = 0, link_data, dev_data, st, rs, ld;
  logic [7:0] q[$];
  logic [4:0] level;
  logic [31:0] rnd = 32'd54981;
  cfc_cfg_s cfg = '0;
  cfc_flow_e rmode;
  cfc_status_s status;
  int err_count = 0, total_checks = 0;

  // --------------------------------------------------------------------
  // Design and device model
  // --------------------------------------------------------------------
  cfc_channel_flow_control #(.PROMPT_INTERVAL(16)) i_dut (
    .clock_i(clock_i), .reset_i(reset_i), .cfg_i(cfg),
    .remote_mode_o(rmode), .status_o(status), .level_o(level),
    .rx_valid_i(rxv), .rx_ready_o(rx_ready), .rx_data_i(rxd),
    .link_valid_o(link_valid), .link_ready_i(lrdy),
    .link_data_o(link_data), .txs_valid_i(txv), .txs_ready_o(txs_ready),
    .txs_data_i(txd), .dev_valid_o(dev_valid), .dev_ready_i(dev_ready),
    .dev_data_o(dev_data), .dtr_i(dtr), .rts_i(rts),
    .reverse_carrier_input_i(rc), .dsr_o(dsr), .cts_o(cts));
  cfc_peer_model i_peer (
    .clock_i(clock_i), .reset_i(reset_i), .dev_valid_i(dev_valid),
    .dev_data_i(dev_data), .dev_ready_o(dev_ready), .slow_i(slow),
    .stop_cnt_o(st), .resume_cnt_o(rs), .last_data_o(ld));

  // --------------------------------------------------------------------
  // Clock, watchdog and helpers
  // --------------------------------------------------------------------
  initial forever #2.5 clock_i = !clock_i;
  initial
  begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    end_of_test();
  end
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic setc(cfc_chan_e c, cfc_flow_e m);
    cfg <= '{chan_type: c, local_mode: m,
             remote_mode: CFC_PROMPTING_TERMINAL_END_MODE};
    wt(4);
  endtask
  // Offers one character until taken, or gives up after 8 edges
  task automatic push(logic [7:0] d);
    rxv <= 1;
    rxd <= d;
    ok = 0;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge clock_i);
      ok = (rx_ready === 1'b1);
    end
    rxv <= 0;
    wt(1);
  endtask
  // Next value of the xorshift sequence
  function automatic logic [31:0] xorshift(logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction
  // Expected go/stop line in polarity mode i (0 to 3) for a stop state
  function automatic logic exp_cts(int i, logic stop);
    exp_cts = (i >= 2) ? stop : !stop;
  endfunction
  // Random data characters kept clear of the stop and resume codes
  task automatic fill(int n);
    for (int i = 0; i < n; i++)
    begin
      rnd = xorshift(rnd);
      push({1'b1, rnd[6:0]});
      if (ok) q.push_back({1'b1, rnd[6:0]});
    end
  endtask
  task automatic drain();
    lrdy <= 1;
    for (int n = 0; n < 60 && q.size() > 0; n++)
    begin
      @(posedge clock_i);
      if (link_valid === 1'b1) chk("link_data", q.pop_front(), link_data);
    end
    lrdy <= 0;
    chk("drained", 0, q.size());
    wt(4);
  endtask
  task automatic send(logic [7:0] d);
    txv <= 1;
    txd <= d;
    ok = 0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge clock_i);
      ok = (txs_ready === 1'b1);
    end
    txv <= 0;
    wt(8);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial
  begin
    logic [7:0] s0;
    wt(2);
    reset_i <= 0;
    wt(2);
    chk("reset", 16'h0180, {status, dsr, cts, dev_valid, link_valid, level});
    // Full buffer refused, stop near full, resume after draining
    setc(CFC_CHAN_ASYNC, CFC_FLOW_DSR_DTR);
    chk("remote_mode", CFC_PROMPTING_TERMINAL_END_MODE, rmode);
    fill(17);
    chk("refused", 0, ok);
    chk("level", 16, level);
    chk("dsr stop", 0, dsr);
    chk("stopping", 1, status.stopping);
    dtr <= 0;
    wt(4);
    chk("dtr gate", 0, txs_ready);
    dtr <= 1;
    wt(4);
    chk("dtr go", 1, txs_ready);
    drain();
    chk("dsr go", 1, dsr);
    // Four polarity modes of the go/stop lines
    for (int i = 0; i < 4; i++)
    begin
      setc(CFC_CHAN_SWITCHED, cfc_flow_e'(3 + i));
      fill(12);
      wt(3);
      chk("cts stop", exp_cts(i, 1'b1), cts);
      rc <= i[0];
      wt(4);
      chk("rc deny", 0, txs_ready);
      rc <= !i[0];
      wt(4);
      chk("rc allow", 1, txs_ready);
      drain();
      chk("cts go", exp_cts(i, 1'b0), cts);
    end
    // Clear-to-send on an async channel acts as no flow control
    setc(CFC_CHAN_ASYNC, CFC_FLOW_CTS_RTS);
    fill(12);
    wt(3);
    chk("async cts", 1, cts);
    drain();
    // Synchronous channel: duplex and request-to-send gating
    setc(CFC_CHAN_SYNC, CFC_FLOW_NONE);
    chk("full duplex", 0, status.half_duplex);
    setc(CFC_CHAN_SYNC, CFC_FLOW_CTS_RTS);
    chk("half duplex", 1, status.half_duplex);
    rts <= 0;
    fill(11);
    wt(3);
    chk("below stop", 1, cts);
    fill(1);
    wt(3);
    chk("sync cts", 0, cts);
    chk("rts gate", 0, txs_ready);
    rts <= 1;
    drain();
    chk("sync cts go", 1, cts);
    // Bidirectional in-band: sends and obeys, stalling device
    setc(CFC_CHAN_ASYNC, CFC_INBAND_BIDIRECTIONAL_MODE);
    slow <= 1;
    fill(12);
    wt(6);
    chk("stop sent", 1, st);
    drain();
    chk("resume sent", 1, rs);
    push(STOP_CHAR);
    wt(4);
    chk("stop obeyed", 0, txs_ready);
    chk("stop consumed", 0, level);
    chk("paused flag", 1, status.peer_paused);
    push(RESUME_CHAR);
    send(8'h5a);
    chk("resume obeyed", 8'h5a, ld);
    // Computer end: received codes are plain data
    setc(CFC_CHAN_ASYNC, CFC_INBAND_COMPUTER_END_MODE);
    push(STOP_CHAR);
    q.push_back(STOP_CHAR);
    wt(4);
    chk("ignored", 1, txs_ready);
    drain();
    // Terminal end: never sends codes
    setc(CFC_CHAN_ASYNC, CFC_INBAND_TERMINAL_END_MODE);
    fill(12);
    wt(6);
    drain();
    chk("no codes", 8'h02, st + rs);
    // Prompting: periodic resume, repeated stop on more data
    setc(CFC_CHAN_ASYNC, CFC_PROMPTING_BIDIRECTIONAL_MODE);
    slow <= 0;
    s0 = rs;
    wt(40);
    chk("prompt", 1, (rs - s0) >= 2);
    fill(12);
    wt(6);
    s0 = st;
    fill(1);
    wt(6);
    chk("stop again", s0 + 8'h01, st);
    drain();
    // Prompting computer end prompts, prompting terminal end stays quiet
    setc(CFC_CHAN_ASYNC, CFC_PROMPTING_COMPUTER_END_MODE);
    s0 = rs;
    wt(40);
    chk("prompt computer", 1, (rs - s0) >= 2);
    setc(CFC_CHAN_ASYNC, CFC_PROMPTING_TERMINAL_END_MODE);
    s0 = st + rs;
    wt(40);
    chk("prompt quiet", s0, st + rs);
    end_of_test();
  end
endmodule
`default_nettype wire
